/* shared/psr_pkg.sv */
// Package for the peripheral soft reset controller: map, fields, types
package psr_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] PSR_PERIPH_RST_OFS = 12'h044; // peripheral_reset_ctrl_b
   localparam logic [11:0] PSR_PORT_RST_OFS = 12'h048; // port_reset_ctrl
   localparam logic [11:0] PSR_CAP_TWO_OFS = 12'h060; // capability_mask_two
   localparam logic [11:0] PSR_CAP_FOUR_OFS = 12'h064; // capability_mask_four

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PSR_COMPARATOR_ONE_RESET_BIT = 25;
   localparam int PSR_COMPARATOR_ZERO_RESET_BIT = 24;
   localparam int PSR_TMR2_BIT = 18;
   localparam int PSR_TMR1_BIT = 17;
   localparam int PSR_TMR0_BIT = 16;
   localparam int PSR_SSER0_BIT = 4;
   localparam int PSR_ASER0_BIT = 0;
   localparam int PSR_NUM_PORTS = 8;

   // Writable bits of each reset register; others read as zero
   localparam logic [31:0] PSR_PERIPH_WMASK = 32'h0307_0011;
   localparam logic [31:0] PSR_PORT_WMASK = 32'h0000_00FF;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] PSR_RST_VAL = 32'h0000_0000;
   // Default capabilities: all documented peripherals present
   localparam logic [31:0] PSR_CAP_TWO_RST = 32'h0307_0011;
   localparam logic [31:0] PSR_CAP_FOUR_RST = 32'h0000_00FF;

   // ****************************************************************
   // Bus encodings
   // ****************************************************************
   localparam logic [1:0] PSR_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PSR_HTRANS_SEQ = 2'h3;
   localparam logic [2:0] PSR_HSIZE_WORD = 3'h2;

   // Peripheral reset outputs grouped together
   typedef struct packed {
      logic comparator_one_reset;
      logic comparator_zero_reset;
      logic gp_counter_two_reset;
      logic gp_counter_one_reset;
      logic gp_counter_zero_reset;
      logic sync_serial_zero_reset;
      logic async_serial_zero_reset;
   } psr_periph_rst_t;

   // Captured address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
   } psr_aphase_t;

endpackage

/* rtl/psr_mask_reg.sv */
// Capability-masked 32-bit reset control register
`timescale 1ns/1ps
module psr_mask_reg
   import psr_pkg::*;
#(
   parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic [31:0] cap_mask,
   output logic [31:0] value
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [31:0] reg_ff; // Held reset control bits
   logic [31:0] nxt_reg; // Next value
   logic [31:0] upd_mask; // Bits that a write may change

   // Next value: only implemented, present bits take write data
   always_comb begin
      upd_mask = WMASK & cap_mask;
      nxt_reg = reg_ff;
      if (wr_en) begin
         // R11: masked bits keep value
         nxt_reg = (reg_ff & ~upd_mask) | (wr_data & upd_mask);
      end
   end

   // Register; synchronous clear to zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // R9: reset loads zero
         reg_ff <= PSR_RST_VAL;
      end else begin
         reg_ff <= nxt_reg;
      end
   end

   // Unassigned bits can never be set, so read as zero
   assign value = reg_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   unused_bits_zero_a: assert property ( // R7
      @(posedge sys_clk) disable iff (rst) (reg_ff & ~WMASK) == 32'h0)
      else $error("unassigned reset bit set");

   masked_bit_hold_a: assert property ( // R11
      @(posedge sys_clk) disable iff (rst)
      wr_en |=> ((reg_ff & ~$past(upd_mask)) ==
                 ($past(reg_ff) & ~$past(upd_mask))))
      else $error("masked reset bit changed on write");
endmodule

/* rtl/psr_ctrl.sv */
// Peripheral soft reset controller with AHB-Lite register slave
// Contract
// R1: Peripheral reset writes masked by capability two
// R2: Port reset writes masked by capability four
// R3: Bits 25,24 reset comparators one, zero
// R4: Bits 18,17,16 reset timers two, one, zero
// R5: Bit 4 sync serial, bit 0 async
// R6: Port register bits 0..7 reset ports A..H
// R7: Unassigned bits read-only, read zero
// R8: Software preserves unassigned bits on writes
// R9: Both registers clear to zero on reset
// R10: Set bit holds peripheral in reset
// R11: Masked write leaves bit unchanged
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module psr_ctrl
   import psr_pkg::*;
#(
   parameter int NUM_PORTS = PSR_NUM_PORTS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output psr_pkg::psr_periph_rst_t periph_rst,
   output logic [NUM_PORTS-1:0] port_rst
);
   import psr_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   psr_aphase_t aph_ff; // Captured address phase
   psr_aphase_t nxt_aph; // Next captured phase
   logic [31:0] hrdata_ff; // Read data register
   logic [31:0] nxt_hrdata; // Next read data
   logic [31:0] cap_two_ff; // capability_mask_two
   logic [31:0] nxt_cap_two;
   logic [31:0] cap_four_ff; // capability_mask_four
   logic [31:0] nxt_cap_four;
   psr_periph_rst_t periph_rst_ff; // Registered peripheral resets
   psr_periph_rst_t nxt_periph_rst;
   logic [NUM_PORTS-1:0] port_rst_ff; // Registered port resets
   logic [NUM_PORTS-1:0] nxt_port_rst;
   logic [31:0] periph_val; // Peripheral register contents
   logic [31:0] port_val; // Port register contents
   logic periph_wr; // Data-phase write to peripheral register
   logic port_wr; // Data-phase write to port register
   logic ap_take; // Address phase accepted this edge

   // Write strobe for a given offset in the current data phase
   function automatic logic wr_hit(input psr_aphase_t a,
                                   input logic [11:0] ofs);
      wr_hit = a.valid && a.write && (a.addr == ofs);
   endfunction

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   // Zero-wait slave: hreadyout stays high, response always OKAY
   assign ap_take = hsel && hready && htrans[1];
   assign periph_wr = wr_hit(aph_ff, PSR_PERIPH_RST_OFS);
   assign port_wr = wr_hit(aph_ff, PSR_PORT_RST_OFS);

   // Next address phase and read data; reads sample registers at
   // the address phase so data is ready at the following edge
   always_comb begin
      nxt_aph = '0;
      nxt_hrdata = hrdata_ff;
      if (hready) begin
         nxt_aph.valid = ap_take && (hsize == PSR_HSIZE_WORD);
         nxt_aph.write = hwrite;
         nxt_aph.addr = {haddr[11:2], 2'b00};
      end
      if (ap_take && !hwrite) begin
         // R7: unmapped and reserved bits return zero
         unique case ({haddr[11:2], 2'b00})
            PSR_PERIPH_RST_OFS: nxt_hrdata = periph_val;
            PSR_PORT_RST_OFS: nxt_hrdata = port_val;
            PSR_CAP_TWO_OFS: nxt_hrdata = cap_two_ff;
            PSR_CAP_FOUR_OFS: nxt_hrdata = cap_four_ff;
            default: nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Capability registers are writable so a system can declare
   // which peripherals are really fitted
   always_comb begin
      nxt_cap_two = cap_two_ff;
      nxt_cap_four = cap_four_ff;
      if (wr_hit(aph_ff, PSR_CAP_TWO_OFS)) begin
         nxt_cap_two = hwdata & PSR_CAP_TWO_RST;
      end
      if (wr_hit(aph_ff, PSR_CAP_FOUR_OFS)) begin
         nxt_cap_four = hwdata & PSR_CAP_FOUR_RST;
      end
   end

   // Bus and capability state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aph_ff <= '0;
         hrdata_ff <= 32'h0000_0000;
         cap_two_ff <= PSR_CAP_TWO_RST;
         cap_four_ff <= PSR_CAP_FOUR_RST;
      end else begin
         aph_ff <= nxt_aph;
         hrdata_ff <= nxt_hrdata;
         cap_two_ff <= nxt_cap_two;
         cap_four_ff <= nxt_cap_four;
      end
   end

   // Constant handshake outputs are flops too, loaded every edge, with no reset
   always_ff @(posedge sys_clk) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end

   assign hrdata = hrdata_ff;

   // ****************************************************************
   // Reset control registers
   // ****************************************************************
   // R1: peripheral writes gated by capability two
   psr_mask_reg #(
      .WMASK(PSR_PERIPH_WMASK)
   ) u_periph_reg (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_en(periph_wr),
      .wr_data(hwdata),
      .cap_mask(cap_two_ff),
      .value(periph_val)
   );

   // R2: port writes gated by capability four
   psr_mask_reg #(
      .WMASK(PSR_PORT_WMASK)
   ) u_port_reg (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_en(port_wr),
      .wr_data(hwdata),
      .cap_mask(cap_four_ff),
      .value(port_val)
   );

   // ****************************************************************
   // Reset outputs
   // ****************************************************************
   // Field decode onto named resets
   always_comb begin
      // R3: comparator reset bits
      nxt_periph_rst.comparator_one_reset = periph_val[PSR_COMPARATOR_ONE_RESET_BIT];
      nxt_periph_rst.comparator_zero_reset = periph_val[PSR_COMPARATOR_ZERO_RESET_BIT];
      // R4: timer reset bits
      nxt_periph_rst.gp_counter_two_reset = periph_val[PSR_TMR2_BIT];
      nxt_periph_rst.gp_counter_one_reset = periph_val[PSR_TMR1_BIT];
      nxt_periph_rst.gp_counter_zero_reset = periph_val[PSR_TMR0_BIT];
      // R5: serial unit reset bits
      nxt_periph_rst.sync_serial_zero_reset = periph_val[PSR_SSER0_BIT];
      nxt_periph_rst.async_serial_zero_reset = periph_val[PSR_ASER0_BIT];
      // R6: port A at bit 0 upward
      nxt_port_rst = port_val[NUM_PORTS-1:0];
   end

   // R10: resets follow held bits, one cycle later
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         periph_rst_ff <= '0;
         port_rst_ff <= '0;
      end else begin
         periph_rst_ff <= nxt_periph_rst;
         port_rst_ff <= nxt_port_rst;
      end
   end

   assign periph_rst = periph_rst_ff;
   assign port_rst = port_rst_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Any bit whose capability is clear must survive every write
   periph_cap_gate_a: assert property ( // R1
      @(posedge sys_clk) disable iff (rst)
      periph_wr |=> ((periph_val & ~$past(cap_two_ff)) ==
                     ($past(periph_val) & ~$past(cap_two_ff))))
      else $error("absent peripheral reset changed");

   port_cap_gate_a: assert property ( // R2
      @(posedge sys_clk) disable iff (rst)
      (port_wr && cap_four_ff[0]) |=> (port_val[0] == $past(hwdata[0])))
      else $error("present port A write not taken");

   comp_map_a: assert property ( // R3
      @(posedge sys_clk) disable iff (rst)
      ##1 periph_rst.comparator_one_reset == $past(periph_val[25]))
      else $error("comparator one reset mismatched");

   timer_map_a: assert property ( // R4
      @(posedge sys_clk) disable iff (rst)
      ##1 periph_rst.gp_counter_two_reset == $past(periph_val[18]))
      else $error("timer two reset mismatched");

   serial_map_a: assert property ( // R5
      @(posedge sys_clk) disable iff (rst)
      ##1 periph_rst.sync_serial_zero_reset == $past(periph_val[4]))
      else $error("sync serial reset mismatched");

   port_h_map_a: assert property ( // R6
      @(posedge sys_clk) disable iff (rst)
      ##1 port_rst[NUM_PORTS-1] == $past(port_val[7]))
      else $error("port H reset mismatched");

   reserved_read_a: assert property ( // R7
      @(posedge sys_clk) disable iff (rst)
      (ap_take && !hwrite && haddr[11:0] == PSR_PORT_RST_OFS) |=>
      hrdata[31:8] == 24'h0)
      else $error("port reserved bits read nonzero");

   reset_clear_a: assert property ( // R9
      @(posedge sys_clk) rst |=> (periph_val == 32'h0 && port_val == 32'h0))
      else $error("reset registers not cleared");

   hold_release_a: assert property ( // R10
      @(posedge sys_clk) disable iff (rst)
      (port_wr && cap_four_ff[1]) |=> ##1 port_rst[1] == $past(hwdata[1], 2))
      else $error("port B reset not following write");

   cov_periph_wr: cover property (@(posedge sys_clk) periph_wr);
   cov_port_wr: cover property (@(posedge sys_clk) port_wr);
   cov_masked_wr: cover property (
      @(posedge sys_clk) periph_wr && cap_two_ff != PSR_CAP_TWO_RST);
   cov_port_all: cover property (
      @(posedge sys_clk) port_rst == {NUM_PORTS{1'b1}});
endmodule

/* verif/peripheral_soft_reset_ctrl_tb.sv */
// Self-checking testbench for the peripheral soft reset controller
`timescale 1ns/1ps
module peripheral_soft_reset_ctrl_tb;
   import psr_pkg::*;
   // ************************************************************
   // Stimulus and observed signals
   // ************************************************************
   logic sys_clk = 1'b0; // 100 MHz system clock
   logic rst = 1'b1; // Synchronous reset, active high
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = PSR_HSIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout; // Single slave, so this is the bus hready too
   logic hresp;
   psr_periph_rst_t periph_rst;
   logic [7:0] port_rst;
   int fails = 0; // Mismatch counter
   int cmp_count = 0; // Comparison counter
   logic [31:0] rd; // Last read word
   // One ordinary case: write, read back, observe the reset lines
   typedef struct {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
      logic [6:0] pexp;
      logic [7:0] gexp;
   } psr_row_t;
   psr_row_t rows[13];

   psr_ctrl dut (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .periph_rst(periph_rst), .port_rst(port_rst)
   );

   // Free-running clock, 10 ns period
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Compare one value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; entered right after a rising edge
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      input logic [2:0] sz = PSR_HSIZE_WORD);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= PSR_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= sz;
      // Hold the address phase until hready is seen high
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      // Data phase; read data is taken at the closing edge
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   // Write a word, then read the same place back and compare
   task automatic wr_rd(input logic [31:0] a, input logic [31:0] d,
                        input logic [31:0] exp);
      bus(1'b1, a, d, rd);
      bus(1'b0, a, 32'h0000_0000, rd);
      check(rd, exp);
   endtask

   // Compare both groups of reset outputs; also the fixed bus answer
   task automatic chk_out(input logic [6:0] pe, input logic [7:0] ge);
      check({25'h0, periph_rst}, {25'h0, pe});
      check({24'h0, port_rst}, {24'h0, ge});
      check({30'h0, hreadyout, hresp}, 32'h0000_0002);
   endtask

   // Verdict; the only place the run ends
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs well under 1000 cycles
   initial begin
      #(5000 * 10);
      fails++;
      summarize();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      // Per-field rows: every writable peripheral bit alone, port bits 0 and 7 alone
      rows[0] = '{32'h044, 32'hFFFF_FFFF, 32'h0307_0011, 7'h7F, 8'h00};
      rows[1] = '{32'h044, 32'h0200_0000, 32'h0200_0000, 7'h40, 8'h00};
      rows[2] = '{32'h044, 32'h0100_0000, 32'h0100_0000, 7'h20, 8'h00};
      rows[3] = '{32'h044, 32'h0004_0000, 32'h0004_0000, 7'h10, 8'h00};
      rows[4] = '{32'h044, 32'h0002_0000, 32'h0002_0000, 7'h08, 8'h00};
      rows[5] = '{32'h044, 32'h0001_0000, 32'h0001_0000, 7'h04, 8'h00};
      rows[6] = '{32'h044, 32'h0000_0010, 32'h0000_0010, 7'h02, 8'h00};
      rows[7] = '{32'h044, 32'hFCF8_FFEF, 32'h0000_0001, 7'h01, 8'h00};
      rows[8] = '{32'h044, 32'h0000_0000, 32'h0000_0000, 7'h00, 8'h00};
      rows[9] = '{32'h048, 32'hFFFF_FFFF, 32'h0000_00FF, 7'h00, 8'hFF};
      rows[10] = '{32'h048, 32'h0000_0001, 32'h0000_0001, 7'h00, 8'h01};
      rows[11] = '{32'h048, 32'hFFFF_FF80, 32'h0000_0080, 7'h00, 8'h80};
      rows[12] = '{32'h048, 32'h0000_0000, 32'h0000_0000, 7'h00, 8'h00};
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      // Reset values of both registers and of every output
      bus(1'b0, 32'h044, 32'h0, rd);
      check(rd, 32'h0000_0000);
      bus(1'b0, 32'h048, 32'h0, rd);
      check(rd, 32'h0000_0000);
      chk_out(7'h00, 8'h00);
      $display("test reset_values done");
      // Field positions, reserved bits, reset line levels
      foreach (rows[i]) begin
         wr_rd(rows[i].addr, rows[i].wdata, rows[i].rexp);
         chk_out(rows[i].pexp, rows[i].gexp);
      end
      $display("test field_table done");
      // Absent async serial unit: its set bit cannot be cleared
      wr_rd(32'h044, 32'h0000_0011, 32'h0000_0011);
      wr_rd(32'h060, 32'h0307_0010, 32'h0307_0010);
      wr_rd(32'h044, 32'h0000_0000, 32'h0000_0001);
      chk_out(7'h01, 8'h00);
      wr_rd(32'h044, 32'h0307_0011, 32'h0307_0011);
      // Upper ports absent: only ports A..D can be set
      wr_rd(32'h064, 32'h0000_000F, 32'h0000_000F);
      wr_rd(32'h048, 32'hFFFF_FFFF, 32'h0000_000F);
      chk_out(7'h7F, 8'h0F);
      $display("test capability_mask done");
      // Unmapped place: reads zero, write has no effect
      wr_rd(32'h100, 32'hFFFF_FFFF, 32'h0000_0000);
      chk_out(7'h7F, 8'h0F);
      $display("test unmapped done");
      // Read-modify-write keeps every other bit as it was read
      bus(1'b0, 32'h048, 32'h0, rd);
      wr_rd(32'h048, rd & 32'hFFFF_FFFE, 32'h0000_000E);
      chk_out(7'h7F, 8'h0E);
      // A byte-sized write is ignored, the register keeps its value
      bus(1'b1, 32'h048, 32'h0000_00FF, rd, 3'h0);
      bus(1'b0, 32'h048, 32'h0, rd);
      check(rd, 32'h0000_000E);
      $display("test read_modify_write done");
      // Mid-run reset clears registers and restores all capabilities
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      bus(1'b0, 32'h048, 32'h0, rd);
      check(rd, 32'h0000_0000);
      chk_out(7'h00, 8'h00);
      wr_rd(32'h044, 32'hFFFF_FFFF, 32'h0307_0011);
      wr_rd(32'h048, 32'hFFFF_FFFF, 32'h0000_00FF);
      chk_out(7'h7F, 8'hFF);
      $display("test second_reset done");
      summarize();
   end
endmodule
